// ### rtl/clock_status_irq.sv
// status latches, interrupt enables and interrupt pin of the clock synthesizer
// assumes status inputs are asynchronous and register requests are synchronous
`include "clock_status_regs.svh"

// Behaviour
// [RULE1] enabled output-pll unlock latch drives the interrupt pin low
// [RULE2] enabled vcxo-pll unlock latch drives the interrupt pin low
// [RULE3] enabled per-input loss-of-signal latch drives the interrupt pin low
// [RULE4] enabled reference latch interrupts on any change, set or clear
// [RULE5] enabled holdover latch drives the interrupt pin low
// [RULE6] enables reset to 0; a disabled source never asserts the pin
// [RULE7] output-pll lock latch reads 0 after unlock; write 1 clears it
// [RULE8] vcxo-pll lock latch reads 0 after unlock; write 1 clears it
// [RULE9] per-input activity latch reads 0 after signal loss; write 1 clears
// [RULE10] reference latch reads 0 if reference lost; write 1 clears it
// [RULE11] holdover latch reads 0 after holdover entry; write 1 clears it
// [RULE12] two-bit field shows input chosen by the selection machine
// [RULE13] momentary bit reads 0 while output pll unlocked
// [RULE14] momentary bit reads 0 while vcxo pll unlocked
// [RULE15] momentary per-input bit reads 0 while signal loss detected
// [RULE16] momentary bit reads 1 while output-pll calibration runs
// [RULE17] momentary bit reads 1 while the selected input has a reference
// [RULE18] momentary holdover bit reads 0 while in holdover
// [RULE19] pin stays low while any enabled latch pends; writing 0 does nothing
module clock_status_irq (
  input  wire logic                           i_clock,   // 100 mhz register clock
  input  wire logic                           i_rst_n,   // synchronous reset
  input  wire clock_status_pkg::clock_status_t i_status, // raw status, async
  input  wire clock_status_pkg::reg_req_t     i_req,     // register request
  output logic [7:0]                          o_rdata,   // read data, registered
  output logic                                o_irq_out_n // interrupt pin, low active
);

  // ==========================================================================
  // two-stage synchronisers; stage one is read only by stage two
  clock_status_pkg::clock_status_t sync1_ff;
  clock_status_pkg::clock_status_t sync2_ff;

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end else begin
      sync1_ff <= i_status;
      sync2_ff <= sync1_ff;
    end
  end

  // ==========================================================================
  // address decode
  wire wr_en_lock   = i_req.wr && (i_req.addr == `IRQ_EN_LOCK_LOS_ADDR);
  wire wr_en_ref    = i_req.wr && (i_req.addr == `IRQ_EN_REF_HOLD_ADDR);
  wire wr_lat_lock  = i_req.wr && (i_req.addr == `LATCHED_LOCK_LOS_ADDR);
  wire wr_lat_ref   = i_req.wr && (i_req.addr == `LATCHED_REF_HOLD_ADDR);

  // ==========================================================================
  // interrupt enables
  logic       outpll_unlock_irq_en_ff;
  logic       vcxopll_unlock_irq_en_ff;
  logic [1:0] input_los_irq_en_ff;
  logic       reference_irq_en_ff;
  logic       holdover_irq_en_ff;

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      outpll_unlock_irq_en_ff  <= `IRQ_EN_RESET; // RULE6
      vcxopll_unlock_irq_en_ff <= `IRQ_EN_RESET;
      input_los_irq_en_ff      <= {2{`IRQ_EN_RESET}};
      reference_irq_en_ff      <= `IRQ_EN_RESET;
      holdover_irq_en_ff       <= `IRQ_EN_RESET;
    end else begin
      if (wr_en_lock) begin
        outpll_unlock_irq_en_ff  <= i_req.wdata[`BIT_OUTPLL];
        vcxopll_unlock_irq_en_ff <= i_req.wdata[`BIT_VCXOPLL];
        input_los_irq_en_ff      <= i_req.wdata[`BIT_INPUT1:`BIT_INPUT0];
      end
      if (wr_en_ref) begin
        reference_irq_en_ff <= i_req.wdata[`BIT_REF];
        holdover_irq_en_ff  <= i_req.wdata[`BIT_HOLD];
      end
    end
  end

  // ==========================================================================
  // event sources from the synchronised levels
  wire       outpll_unlock_event  = !sync2_ff.outpll_lock_now_n;
  wire       vcxopll_unlock_event = !sync2_ff.vcxopll_lock_now_n;
  wire [1:0] input_los_event      = ~sync2_ff.input_active_now;
  wire       holdover_event       = !sync2_ff.holdover_now_n;
  wire       reference_lost_event = !sync2_ff.reference_present_now;

  // ==========================================================================
  // clear strobes; a zero bit in the write leaves its latch alone
  wire       clr_outpll  = wr_lat_lock && i_req.wdata[`BIT_OUTPLL];  // RULE19
  wire       clr_vcxopll = wr_lat_lock && i_req.wdata[`BIT_VCXOPLL];
  wire [1:0] clr_input   = {2{wr_lat_lock}} & i_req.wdata[`BIT_INPUT1:`BIT_INPUT0];
  wire       clr_ref     = wr_lat_ref && i_req.wdata[`BIT_REF];
  wire       clr_hold    = wr_lat_ref && i_req.wdata[`BIT_HOLD];

  // ==========================================================================
  // sticky event latches, stored as "event seen"; set beats clear so a
  // condition still present at the clear re-arms the latch at once
  logic       outpll_seen_ff;
  logic       vcxopll_seen_ff;
  logic [1:0] input_seen_ff;
  logic       ref_lost_ff;
  logic       hold_seen_ff;
  logic       ref_pend_ff;     // reference change pending
  logic       ref_prev_ff;     // reference latch value last cycle

  wire       nxt_outpll_seen  = outpll_unlock_event  | (outpll_seen_ff  & !clr_outpll);
  wire       nxt_vcxopll_seen = vcxopll_unlock_event | (vcxopll_seen_ff & !clr_vcxopll);
  wire [1:0] nxt_input_seen   = input_los_event | (input_seen_ff & ~clr_input);
  wire       nxt_ref_lost     = reference_lost_event | (ref_lost_ff & !clr_ref);
  wire       nxt_hold_seen    = holdover_event | (hold_seen_ff & !clr_hold);

  // reference status bit as read: 1 while valid since last clear
  wire reference_valid_latched = !ref_lost_ff;
  wire ref_changed             = reference_valid_latched != ref_prev_ff;
  wire nxt_ref_pend            = ref_changed | (ref_pend_ff & !clr_ref);

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      outpll_seen_ff  <= `LATCH_RESET;
      vcxopll_seen_ff <= `LATCH_RESET;
      input_seen_ff   <= {2{`LATCH_RESET}};
      ref_lost_ff     <= `LATCH_RESET;
      hold_seen_ff    <= `LATCH_RESET;
      ref_pend_ff     <= `LATCH_RESET;
      ref_prev_ff     <= 1'b1;
    end else begin
      outpll_seen_ff  <= nxt_outpll_seen;   // RULE7
      vcxopll_seen_ff <= nxt_vcxopll_seen;  // RULE8
      input_seen_ff   <= nxt_input_seen;    // RULE9
      ref_lost_ff     <= nxt_ref_lost;      // RULE10
      hold_seen_ff    <= nxt_hold_seen;     // RULE11
      ref_pend_ff     <= nxt_ref_pend;      // RULE4
      ref_prev_ff     <= reference_valid_latched;
    end
  end

  // ==========================================================================
  // interrupt gating; the pin tracks pending enabled latches
  wire irq_outpll  = outpll_unlock_irq_en_ff  & outpll_seen_ff;   // RULE1
  wire irq_vcxopll = vcxopll_unlock_irq_en_ff & vcxopll_seen_ff;  // RULE2
  wire irq_input   = |(input_los_irq_en_ff & input_seen_ff);      // RULE3
  wire irq_ref     = reference_irq_en_ff & ref_pend_ff;           // RULE4
  wire irq_hold    = holdover_irq_en_ff & hold_seen_ff;           // RULE5
  wire nxt_irq_out_n = !(irq_outpll | irq_vcxopll | irq_input | irq_ref | irq_hold); // RULE6

  logic irq_out_n_ff;

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      irq_out_n_ff <= 1'b1;
    end else begin
      irq_out_n_ff <= nxt_irq_out_n; // RULE19
    end
  end

  assign o_irq_out_n = irq_out_n_ff;

  // ==========================================================================
  // read data images
  wire [7:0] img_en_lock = {2'b00, outpll_unlock_irq_en_ff, vcxopll_unlock_irq_en_ff,
                            2'b00, input_los_irq_en_ff};
  wire [7:0] img_en_ref  = {6'b000000, reference_irq_en_ff, holdover_irq_en_ff};
  wire [7:0] img_lat_lock = {2'b00, !outpll_seen_ff, !vcxopll_seen_ff,
                             2'b00, ~input_seen_ff};
  wire [7:0] img_mom_lock = {sync2_ff.selected_input_code,            // RULE12
                             sync2_ff.outpll_lock_now_n,              // RULE13
                             sync2_ff.vcxopll_lock_now_n,             // RULE14
                             2'b00, sync2_ff.input_active_now};       // RULE15
  wire [7:0] img_lat_ref = {6'b000000, reference_valid_latched, !hold_seen_ff};
  wire [7:0] img_mom_cal = {5'b00000,
                            sync2_ff.outpll_cal_running,              // RULE16
                            sync2_ff.reference_present_now,           // RULE17
                            sync2_ff.holdover_now_n};                 // RULE18

  // ==========================================================================
  // read mux; unmapped offsets read zero
  wire [7:0] nxt_rdata =
    (i_req.addr == `IRQ_EN_LOCK_LOS_ADDR)    ? img_en_lock  :
    (i_req.addr == `IRQ_EN_REF_HOLD_ADDR)    ? img_en_ref   :
    (i_req.addr == `LATCHED_LOCK_LOS_ADDR)   ? img_lat_lock :
    (i_req.addr == `MOMENTARY_SEL_LOCK_ADDR) ? img_mom_lock :
    (i_req.addr == `LATCHED_REF_HOLD_ADDR)   ? img_lat_ref  :
    (i_req.addr == `MOMENTARY_CAL_REF_ADDR)  ? img_mom_cal  : `READ_ZERO;

  logic [7:0] rdata_ff;

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      rdata_ff <= `READ_ZERO;
    end else if (i_req.rd) begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign o_rdata = rdata_ff;

endmodule

// ### rtl/clock_status_regs.svh
// register offsets, field positions and reset values of the clock status block
// assumes an 8-bit register port with 7-bit addresses from the serial front end
`ifndef CLOCK_STATUS_REGS_SVH
`define CLOCK_STATUS_REGS_SVH

// ==========================================================================
// register offsets
`define IRQ_EN_LOCK_LOS_ADDR      7'h68
`define IRQ_EN_REF_HOLD_ADDR      7'h69
`define LATCHED_LOCK_LOS_ADDR     7'h6c
`define MOMENTARY_SEL_LOCK_ADDR   7'h6d
`define LATCHED_REF_HOLD_ADDR     7'h6e
`define MOMENTARY_CAL_REF_ADDR    7'h6f

// ==========================================================================
// field positions
`define BIT_INPUT0                0
`define BIT_INPUT1                1
`define BIT_VCXOPLL               4
`define BIT_OUTPLL                5
`define BIT_SEL_LO                6
`define BIT_HOLD                  0
`define BIT_REF                   1
`define BIT_CAL                   2

// ==========================================================================
// reset values
`define IRQ_EN_RESET              1'b0
`define LATCH_RESET               1'b0
`define READ_ZERO                 8'h00

`endif

// ### rtl/clock_status_pkg.sv
// types shared by the clock status block
// assumes the header clock_status_regs.svh supplies all numbers
package clock_status_pkg;

  // ==========================================================================
  // momentary conditions from the analog and selection logic
  typedef struct packed {
    logic       outpll_lock_now_n;    // 0 = output pll unlocked
    logic       vcxopll_lock_now_n;   // 0 = vcxo pll unlocked
    logic [1:0] input_active_now;     // 1 = input clock active
    logic       reference_present_now;
    logic       holdover_now_n;       // 0 = in holdover
    logic       outpll_cal_running;
    logic [1:0] selected_input_code;  // 00 input 0, 01 input 1
  } clock_status_t;

  // ==========================================================================
  // register port request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [6:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

endpackage

// ### testbench/clock_status_source.sv
// far-side model: pll monitors, input monitors and selector on the status port
// assumes the bench drives a fault mask; each set bit flips a field from healthy
module clock_status_source (
  input  wire logic [8:0]                 i_fault,  // fault mask from the bench
  output clock_status_pkg::clock_status_t o_status  // status levels to the block
);
  timeunit 1ns;
  timeprecision 1ps;
  // healthy: plls locked, inputs active, reference present, no holdover, input 0
  assign o_status = clock_status_pkg::clock_status_t'(9'h1f8 ^ i_fault);
endmodule

// ### testbench/clock_status_irq_properties.sv
// checker for the clock status block, sees only its top-level ports
// assumes the bench holds status steady while it reads momentary registers
module clock_status_irq_properties (
  input wire logic                            i_clock,     // register clock
  input wire logic                            i_rst_n,     // sync reset
  input wire clock_status_pkg::clock_status_t i_status,    // raw status
  input wire clock_status_pkg::reg_req_t      i_req,       // register request
  input wire logic [7:0]                      o_rdata,     // read data
  input wire logic                            o_irq_out_n  // interrupt pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // shadow enables and status age; age saturates so reads wait out the synchroniser
  logic [5:0] en_ff;
  logic [1:0] age_ff;
  logic [7:0] img_d_ff;
  logic [7:0] img_f_ff;
  clock_status_pkg::clock_status_t prev_ff;
  wire rd_d = i_req.rd && i_req.addr == 7'h6d && age_ff == 2'h3;
  wire rd_f = i_req.rd && i_req.addr == 7'h6f && age_ff == 2'h3;
  always_ff @(posedge i_clock) begin
    prev_ff  <= i_status;
    img_d_ff <= {i_status[1:0], i_status[8:7], 2'h0, i_status[6:5]};
    img_f_ff <= {5'h00, i_status[2], i_status[4], i_status[3]};
    age_ff   <= (!i_rst_n || i_status != prev_ff) ? 2'h0 : age_ff + {1'h0, age_ff != 2'h3};
    if (!i_rst_n) en_ff <= 6'h00;
    else if (i_req.wr && i_req.addr == 7'h68) en_ff[5:2] <= {i_req.wdata[5:4], i_req.wdata[1:0]};
    else if (i_req.wr && i_req.addr == 7'h69) en_ff[1:0] <= i_req.wdata[1:0];
  end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  // ==========================================================================
  // interrupt pin
  outpll_irq_a: assert property (en_ff[5] && $fell(i_status.outpll_lock_now_n) |-> ##[1:6] !o_irq_out_n)
    else $error("output pll unlock not flagged");
  vcxo_irq_a: assert property (en_ff[4] && $fell(i_status.vcxopll_lock_now_n) |-> ##[1:6] !o_irq_out_n)
    else $error("vcxo pll unlock not flagged");
  input_irq_a: assert property (|(en_ff[3:2] & $past(i_status.input_active_now) & ~i_status.input_active_now) |-> ##[1:6] !o_irq_out_n)
    else $error("input signal loss not flagged");
  ref_irq_a: assert property (en_ff[1] && $fell(i_status.reference_present_now) |-> ##[1:6] !o_irq_out_n)
    else $error("reference change not flagged");
  hold_irq_a: assert property (en_ff[0] && $fell(i_status.holdover_now_n) |-> ##[1:6] !o_irq_out_n)
    else $error("holdover not flagged");
  masked_quiet_a: assert property ((en_ff == 6'h00) [*3] |-> o_irq_out_n)
    else $error("pin low with all sources masked");
  // ==========================================================================
  // momentary registers
  sel_lock_read_a: assert property (rd_d |=> o_rdata == img_d_ff)
    else $error("selection and lock image wrong");
  cal_ref_read_a: assert property (rd_f |=> o_rdata == img_f_ff)
    else $error("calibration and reference image wrong");
endmodule

bind clock_status_irq clock_status_irq_properties u_clock_status_irq_properties (
  .i_clock(i_clock), .i_rst_n(i_rst_n), .i_status(i_status), .i_req(i_req),
  .o_rdata(o_rdata), .o_irq_out_n(o_irq_out_n));

// ### testbench/clock_status_irq_test.sv
// self-checking bench for the clock status block
// assumes the status source model drives the status port from a fault mask
module clock_status_irq_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic                            i_clock = 1'b0;
  logic                            i_rst_n = 1'b0;
  logic [8:0]                      fault   = 9'h000;
  clock_status_pkg::reg_req_t      req     = 17'h00000;
  clock_status_pkg::clock_status_t status;
  logic [7:0]                      rdata;
  logic                            irq_n;
  int                              error_cnt = 0;
  int                              cmp_count = 0;
  int                              cycles    = 0;
  clock_status_source u_clock_status_source (.i_fault(fault), .o_status(status));
  clock_status_irq u_clock_status_irq (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_status(status),
    .i_req(req), .o_rdata(rdata), .o_irq_out_n(irq_n));
  // ==========================================================================
  // clock and hang guard; the whole run needs well under a thousand cycles
  initial begin
    forever #5 i_clock = ~i_clock;
  end
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 3000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  // ==========================================================================
  // shared tasks; a request is held one edge, the answer is read one edge later
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic access(input logic wr, input logic [6:0] addr, input logic [7:0] data);
    req <= {wr, ~wr, addr, data};
    @(posedge i_clock);
    req <= 17'h00000;
    @(posedge i_clock);
  endtask
  task automatic rd_chk(input logic [6:0] addr, input logic [7:0] exp);
    access(1'b0, addr, 8'h00);
    check(rdata, exp);
  endtask
  // start-up latches are set by the synchroniser reset, so clear them first
  task automatic t_idle();
    repeat (4) @(posedge i_clock);
    rd_chk(7'h68, 8'h00);
    rd_chk(7'h69, 8'h00);
    access(1'b1, 7'h6c, 8'hff);
    access(1'b1, 7'h6e, 8'hff);
    rd_chk(7'h6c, 8'h33);
    rd_chk(7'h6e, 8'h03);
    rd_chk(7'h6d, 8'h33);
    rd_chk(7'h6f, 8'h03);
    rd_chk(7'h6a, 8'h00); // unmapped place reads zero
    fault <= 9'h005;
    repeat (4) @(posedge i_clock);
    rd_chk(7'h6d, 8'h73);
    rd_chk(7'h6f, 8'h07);
    fault <= 9'h000;
  endtask
  // each source twice: masked, then enabled; then write 0, then write 1
  task automatic t_sources();
    logic [8:0] f [6] = '{9'h100, 9'h080, 9'h040, 9'h020, 9'h010, 9'h008};
    logic [7:0] en [6] = '{8'h20, 8'h10, 8'h02, 8'h01, 8'h02, 8'h01};
    logic [7:0] lt [6] = '{8'h13, 8'h23, 8'h31, 8'h32, 8'h01, 8'h02};
    for (int i = 0; i < 6; i++) begin
      for (int on = 0; on < 2; on++) begin
        access(1'b1, (i < 4) ? 7'h68 : 7'h69, on ? en[i] : 8'h00);
        fault <= f[i];
        repeat (3) @(posedge i_clock);
        fault <= 9'h000;
        for (int k = 0; k < 8 && irq_n !== 1'b0; k++) @(posedge i_clock);
        check({7'h00, irq_n}, on ? 8'h00 : 8'h01);
        rd_chk((i < 4) ? 7'h6c : 7'h6e, lt[i]);
        access(1'b1, (i < 4) ? 7'h6c : 7'h6e, 8'h00);
        rd_chk((i < 4) ? 7'h6c : 7'h6e, lt[i]);
        access(1'b1, (i < 4) ? 7'h6c : 7'h6e, en[i]);
        repeat (2) @(posedge i_clock);
        // a cleared reference latch changes again, so its pin is not judged here
        if (i != 4) check({7'h00, irq_n}, 8'h01);
        rd_chk((i < 4) ? 7'h6c : 7'h6e, (i < 4) ? 8'h33 : 8'h03);
      end
    end
  endtask
  // a condition still present at the clear re-arms the latch, then a mid-run reset
  task automatic t_set_wins();
    fault <= 9'h100;
    repeat (4) @(posedge i_clock);
    access(1'b1, 7'h6c, 8'h20);
    rd_chk(7'h6c, 8'h13);
    fault <= 9'h000;
    repeat (4) @(posedge i_clock);
    access(1'b1, 7'h6c, 8'h20);
    rd_chk(7'h6c, 8'h33);
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_clock);
    i_rst_n <= 1'b1;
    @(posedge i_clock);
    rd_chk(7'h68, 8'h00);
    rd_chk(7'h69, 8'h00);
    check({7'h00, irq_n}, 8'h01);
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ==========================================================================
  // main sequence
  initial begin
    repeat (8) @(posedge i_clock);
    i_rst_n <= 1'b1;
    t_idle();
    t_sources();
    t_set_wins();
    report_and_stop();
  end
endmodule
